// ### src/fosr_core.sv
// Flash program and erase status readout core
// Notes on behaviour
// R1: Reads during a program or erase return the status byte, not array data.
// R2: Program polling bit reads inverted bit 7, then true data when done.
// R3: Polling status valid only after fourth program or sixth erase pulse.
// R4: Host polls at the programmed address or inside the erased sector.
// R5: Erase polling bit reads 0 while busy, stored value afterwards.
// R6: Program aimed at a protected sector is ignored, byte unchanged.
// R7: Erase of only protected sectors shows polling 0 about 100 us, no erase.
// R8: Toggle bit flips on each selected read while internal write runs.
// R9: When the cycle ends toggling stops and array data is returned.
// R10: Host deems operation finished after two identical consecutive reads.
// R11: Toggle status valid only after fourth program or sixth erase pulse.
// R12: Protected-only erase toggles about 100 us then returns array data.
// R13: Error flag 0 in correct operation, 1 on any program or erase failure.
// R14: Error raised when programming tries to turn a 0 bit into 1.
// R15: Error raised when byte programming exceeds its time limit.
// R16: Host stops using a sector after an error there.
// R17: Error flag holds until a reset instruction clears it.
// R18: Erase timeout bit 0 for window after sector erase, then 1.
// R19: Status reads have no side effect on the running operation.
// R20: Host re-checks polling bit when error flag reads 1.
// R21: Toggle bit advances only on selected reads.
`timescale 1ns/100ps
`default_nettype none
module fosr_core
  import fosr_pkg::*;
#(
  parameter int unsigned PROT_CYC  = PROT_ERASE_CYC,
  parameter int unsigned WIN_CYC   = ERASE_WIN_CYC,
  parameter int unsigned PROG_CYC  = PROG_TIME_CYC,
  parameter int unsigned ERASE_CYC = ERASE_TIME_CYC,
  parameter int unsigned PROG_LIMIT_CYC = 2 * PROG_TIME_CYC
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Host bus pins
  input  wire logic       main_sector_select,
  input  wire logic       secondary_sector_select,
  input  wire logic       read_strobe,
  input  wire logic       write_strobe,
  output logic [7:0]      host_data_bus,
  // Decoded instructions
  input  wire logic       cmd_program,
  input  wire logic       cmd_sector_erase,
  input  wire logic       cmd_bulk_erase,
  input  wire logic       cmd_reset,
  input  wire logic [7:0] prog_data,
  input  wire logic       target_protected,
  input  wire logic [7:0] array_data,
  input  wire logic       erase_fail,
  input  wire logic       prog_stall,
  // Status view
  output logic            busy,
  output logic            array_write,
  output logic            array_erase
);
  // Pin synchronisers
  logic ms_lvl_w;
  logic ss_lvl_w;
  logic rd_rise_w;
  logic wr_rise_w;
  fosr_sync u_sync_ms (
    .clk  (clk),
    .rst  (rst),
    .pin  (main_sector_select),
    .lvl  (ms_lvl_w),
    .rise ()
  );
  fosr_sync u_sync_ss (
    .clk  (clk),
    .rst  (rst),
    .pin  (secondary_sector_select),
    .lvl  (ss_lvl_w),
    .rise ()
  );
  fosr_sync u_sync_rd (
    .clk  (clk),
    .rst  (rst),
    .pin  (read_strobe),
    .lvl  (),
    .rise (rd_rise_w)
  );
  fosr_sync u_sync_wr (
    .clk  (clk),
    .rst  (rst),
    .pin  (write_strobe),
    .lvl  (),
    .rise (wr_rise_w)
  );

  wire sel_w      = ms_lvl_w | ss_lvl_w;
  wire sel_read_w = rd_rise_w & sel_w;

  fosr_state_t state_r, state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic [15:0] win_r;
  logic [2:0]  pulse_r;
  logic [7:0]  data_r;
  logic        toggle_r;
  logic        error_r;
  logic        eto_r;
  logic        valid_r;
  logic        is_erase_r;

  wire [15:0] prot_cyc_w  = 16'(PROT_CYC);
  wire [15:0] win_cyc_w   = 16'(WIN_CYC);
  wire [15:0] prog_cyc_w  = 16'(PROG_CYC);
  wire [15:0] erase_cyc_w = 16'(ERASE_CYC);
  wire [15:0] limit_w     = 16'(PROG_LIMIT_CYC);
  // R14 bad transition
  wire bad_bits_w  = |(prog_data & ~array_data);
  wire prog_done_w = (state_r == FOSR_PROG) && !prog_stall && (cnt_r >= prog_cyc_w - 16'h0001);
  // R15 program timeout
  wire prog_tmo_w  = (state_r == FOSR_PROG) && (cnt_r >= limit_w - 16'h0001);
  wire erase_start_w = (state_r == FOSR_ERASE_WAIT) && (win_r == 16'h0000);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 16'h0001;
    case (state_r)
      FOSR_IDLE: begin
        cnt_nxt = 16'h0000;
        // R6 protected program
        if (cmd_program && !target_protected) begin
          state_nxt = FOSR_PROG;
        end else if (cmd_bulk_erase || cmd_sector_erase) begin
          // R7 protected erase
          state_nxt = target_protected ? FOSR_PROT_ERASE : FOSR_ERASE_WAIT;
        end
      end
      FOSR_PROG: begin
        if (prog_done_w || prog_tmo_w) begin
          state_nxt = FOSR_IDLE;
        end
      end
      FOSR_ERASE_WAIT: begin
        cnt_nxt = 16'h0000;
        if (erase_start_w) begin
          state_nxt = FOSR_ERASE;
        end
      end
      FOSR_ERASE: begin
        if (cnt_r >= erase_cyc_w - 16'h0001) begin
          state_nxt = FOSR_IDLE;
        end
      end
      FOSR_PROT_ERASE: begin
        // R12 protected window
        if (cnt_r >= prot_cyc_w - 16'h0001) begin
          state_nxt = FOSR_IDLE;
        end
      end
      default: state_nxt = FOSR_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= FOSR_IDLE;
      cnt_r   <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // R18 erase timeout window
  wire eto_load_w = cmd_sector_erase && (state_r == FOSR_IDLE) && !target_protected;
  wire eto_end_w  = cmd_sector_erase && (state_r == FOSR_ERASE_WAIT);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      win_r <= 16'h0000;
      eto_r <= 1'b1;
    end else if (eto_load_w) begin
      win_r <= win_cyc_w;
      eto_r <= 1'b0;
    end else if (eto_end_w) begin
      win_r <= 16'h0000;
      eto_r <= 1'b1;
    end else if (win_r != 16'h0000) begin
      win_r <= win_r - 16'h0001;
      eto_r <= (win_r == 16'h0001);
    end else begin
      eto_r <= 1'b1;
    end
  end

  // R3 write pulse count, saturating so a long run never wraps
  wire cmd_any_w   = cmd_program || cmd_sector_erase || cmd_bulk_erase;
  wire pulse_max_w = (pulse_r == 3'h7);
  wire prog_ok_w   = (pulse_r >= 3'(PROG_VALID_PULSE));
  wire erase_ok_w  = (pulse_r >= 3'(ERASE_VALID_PULSE));
  wire wr_sel_w    = wr_rise_w && sel_w && !pulse_max_w;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pulse_r    <= 3'h0;
      valid_r    <= 1'b0;
      is_erase_r <= 1'b0;
    end else if (state_r == FOSR_IDLE && !cmd_any_w) begin
      pulse_r    <= wr_sel_w ? 3'(pulse_r + 3'h1) : pulse_r;
      valid_r    <= 1'b0;
      is_erase_r <= 1'b0;
    end else if (state_r == FOSR_IDLE) begin
      is_erase_r <= (state_nxt != FOSR_PROG);
      // R11 toggle validity
      valid_r    <= (state_nxt == FOSR_PROG) ? prog_ok_w : erase_ok_w;
      pulse_r    <= 3'h0;
    end
  end

  wire data_load_w = (state_r == FOSR_IDLE) && cmd_program;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_r <= ERASED_BYTE;
    end else if (data_load_w) begin
      data_r <= prog_data;
    end
  end

  // R8 toggle on selected reads
  // R21 selected reads only
  wire toggle_adv_w = busy && sel_read_w;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggle_r <= 1'b0;
    end else if (toggle_adv_w) begin
      toggle_r <= ~toggle_r;
    end
  end

  // R13 error flag set
  // R17 cleared by reset instruction, set wins
  wire prog_err_w  = (state_r == FOSR_PROG) && bad_bits_w;
  wire erase_err_w = (state_r == FOSR_ERASE) && erase_fail;
  wire err_set_w   = prog_tmo_w || prog_err_w || erase_err_w;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      error_r <= 1'b0;
    end else if (err_set_w) begin
      error_r <= 1'b1;
    end else if (cmd_reset) begin
      error_r <= 1'b0;
    end
  end

  assign busy        = (state_r != FOSR_IDLE);
  assign array_write = prog_done_w && !error_r && !bad_bits_w;
  assign array_erase = (state_r == FOSR_ERASE) && (cnt_r == 16'h0000);

  // R2 inverted bit 7 while programming
  // R5 erase reads zero
  // R7 protected erase reads zero
  wire poll_w = is_erase_r ? 1'b0 : ~data_r[POLL_BIT_POS];
  logic [7:0] status_w;
  always_comb begin
    status_w = STATUS_RST;
    status_w[POLL_BIT_POS]   = poll_w;
    status_w[TOGGLE_BIT_POS] = toggle_r;
    status_w[ERROR_BIT_POS]  = error_r;
    status_w[ETO_BIT_POS]    = eto_r;
  end

  // R1 status replaces array data
  // R9 array data when idle
  // R19 reads leave operation alone
  wire show_status_w = busy && valid_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      host_data_bus <= STATUS_RST;
    end else if (show_status_w) begin
      host_data_bus <= status_w;
    end else begin
      host_data_bus <= array_data;
    end
  end
endmodule

// Three-stage shift for an asynchronous pin: two sync stages and one for edges
module fosr_sync
  import fosr_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin and synchronised view
  input  wire logic pin,
  output logic      lvl,
  output logic      rise
);
  logic [2:0] shift_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_r <= 3'h0;
    end else begin
      shift_r <= {shift_r[1:0], pin};
    end
  end
  assign lvl  = shift_r[1];
  assign rise = shift_r[1] & ~shift_r[2];
endmodule
`default_nettype wire

// ### inc/fosr_pkg.sv
// Shared constants for the flash operation status readout block
package fosr_pkg;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned PROT_ERASE_US    = 100;
  localparam int unsigned PROT_ERASE_CYC   = PROT_ERASE_US * CLK_MHZ;
  localparam int unsigned ERASE_WIN_US     = 120;
  localparam int unsigned ERASE_WIN_CYC    = ERASE_WIN_US * CLK_MHZ;
  localparam int unsigned PROG_TIME_CYC    = 1000;
  localparam int unsigned ERASE_TIME_CYC   = 10000;
  localparam int unsigned PROG_VALID_PULSE = 4;
  localparam int unsigned ERASE_VALID_PULSE = 6;
  localparam int unsigned POLL_BIT_POS     = 7;
  localparam int unsigned TOGGLE_BIT_POS   = 6;
  localparam int unsigned ERROR_BIT_POS    = 5;
  localparam int unsigned ETO_BIT_POS      = 3;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  localparam logic [7:0]  STATUS_RST       = 8'h00;
  typedef enum logic [2:0] {
    FOSR_IDLE, FOSR_PROG, FOSR_ERASE_WAIT, FOSR_ERASE, FOSR_PROT_ERASE
  } fosr_state_t;
endpackage

// ### testbench/fosr_chk.sv
// Assertion checker for the status readout core
`timescale 1ns/100ps
`default_nettype none
module fosr_chk (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Watched ports
  input  wire logic       cmd_program,
  input  wire logic       cmd_sector_erase,
  input  wire logic       cmd_bulk_erase,
  input  wire logic       target_protected,
  input  wire logic [7:0] array_data,
  input  wire logic [7:0] host_data_bus,
  input  wire logic       busy,
  input  wire logic       array_write,
  input  wire logic       array_erase
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic go  = !busy && !target_protected;
  wire logic pp  = !busy && target_protected;
  wire logic cmd = cmd_program || cmd_sector_erase || cmd_bulk_erase;
  AST_PROG_BUSY: assert property (go && cmd_program |=> busy [*8])
    else $error("program busy too short");
  AST_PROG_END: assert property (go && cmd_program |=> busy ##[1:60] !busy)
    else $error("program never ends");
  AST_PROT_PROG: assert property (pp && cmd_program |=> (!busy && !array_write) [*4])
    else $error("protected program ran");
  AST_PROT_ERASE: assert property (pp && cmd_sector_erase |=> (busy && !array_erase) [*8])
    else $error("protected erase ran");
  AST_ERASE_WIN: assert property (go && cmd_sector_erase |=> !array_erase throughout busy [*8])
    else $error("erase began inside window");
  AST_IDLE_DATA: assert property (!$past(busy) && !$past(rst)
    |-> host_data_bus == $past(array_data)) else $error("idle bus not array data");
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> $past(cmd))
    else $error("busy without command");
  AST_PAD_ZERO: assert property (busy && $past(busy)
    |-> host_data_bus == $past(array_data) || (host_data_bus & 8'h17) == 8'h00)
    else $error("unused status bits set");
  cover property (array_write);
  cover property (array_erase);
  cover property (busy && host_data_bus[6]);
endmodule
bind fosr_core fosr_chk u_fosr_chk (.clk, .rst, .cmd_program, .cmd_sector_erase,
  .cmd_bulk_erase, .target_protected, .array_data, .host_data_bus, .busy, .array_write,
  .array_erase);
`default_nettype wire

// ### testbench/fosr_mcu.sv
// Microcontroller model on the host bus
`timescale 1ns/100ps
`default_nettype none
module fosr_mcu (
  // Clock
  input  wire logic       clk,
  // Selects and strobes
  output logic            main_sector_select,
  output logic            secondary_sector_select,
  output logic            read_strobe,
  output logic            write_strobe,
  // Read data
  input  wire logic [7:0] host_data_bus,
  output logic [7:0]      rdata,
  output logic            rd_done
);
  initial begin
    {main_sector_select, secondary_sector_select, read_strobe, write_strobe, rd_done} = '0;
  end
  // cycles stay at the polled byte
  task automatic cyc(input logic sec, input logic w);
    @(posedge clk);
    main_sector_select <= !sec;
    secondary_sector_select <= sec;
    read_strobe <= !w;
    write_strobe <= w;
    repeat (6) @(posedge clk);
    rdata <= host_data_bus;
    rd_done <= !w;
    {main_sector_select, secondary_sector_select, read_strobe, write_strobe} <= '0;
    @(posedge clk);
    rd_done <= 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) cyc(1'b0, 1'b1);
  endtask
  task automatic poll(input logic sec);
    logic [7:0] prev;
    cyc(sec, 1'b0);
    repeat (40) begin
      prev = rdata;
      cyc(sec, 1'b0);
      if (rdata === prev) break;
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/flash_op_status_readout_tb_top.sv
// Testbench for the status readout core
`timescale 1ns/100ps
`default_nettype none
module flash_op_status_readout_tb_top;
  logic        clk, rst, main_sector_select, secondary_sector_select, read_strobe;
  logic        write_strobe, cmd_program, cmd_sector_erase, cmd_bulk_erase, cmd_reset;
  logic        target_protected, erase_fail, prog_stall, busy, array_write, array_erase;
  logic        rd_done, tgl;
  logic [7:0]  host_data_bus, prog_data, array_data, rdata, d;
  logic [15:0] q[$];
  logic [31:0] seed;
  int          n_fail, comparisons;
  fosr_core #(.PROT_CYC(20), .WIN_CYC(30), .PROG_CYC(10), .ERASE_CYC(20), .PROG_LIMIT_CYC(40))
    u_fosr_core (.clk, .rst, .main_sector_select, .secondary_sector_select, .read_strobe,
    .write_strobe, .host_data_bus, .cmd_program, .cmd_sector_erase, .cmd_bulk_erase,
    .cmd_reset, .prog_data, .target_protected, .array_data, .erase_fail, .prog_stall, .busy,
    .array_write, .array_erase);
  fosr_mcu u_fosr_mcu (.clk, .main_sector_select, .secondary_sector_select, .read_strobe,
    .write_strobe, .host_data_bus, .rdata, .rd_done);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL host_data_bus expected %h seen %h", exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic note(input logic [7:0] mask, input logic [7:0] exp);
    q.push_back({mask, exp});
    u_fosr_mcu.cyc(1'b0, 1'b0);
  endtask
  task automatic cmd(input logic er, input logic p, input logic [7:0] v);
    @(posedge clk);
    target_protected <= p;
    prog_data <= v;
    cmd_program <= !er;
    cmd_sector_erase <= er;
    @(posedge clk);
    {cmd_program, cmd_sector_erase} <= 2'b00;
  endtask
  // Array byte under the polled address
  always @(posedge clk) begin
    if (array_write) array_data <= prog_data;
    if (array_erase) array_data <= 8'hFF;
  end
  task automatic bulk();
    @(posedge clk);
    target_protected <= 1'b0;
    cmd_bulk_erase <= 1'b1;
    @(posedge clk);
    cmd_bulk_erase <= 1'b0;
  endtask
  // Compare between edges so a note pushed on an edge never meets an older read
  always @(negedge clk) begin
    if (rd_done && q.size() > 0) begin
      check(rdata & q[0][15:8], q[0][7:0]);
      void'(q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    {rst, cmd_program, cmd_sector_erase, cmd_bulk_erase, cmd_reset} = 5'b10000;
    {target_protected, erase_fail, prog_stall, prog_data, array_data} = {3'b000, 16'h00FF};
    seed = 32'h33b7;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    d = 8'(rnd());
    u_fosr_mcu.pulses(4);
    prog_stall <= 1'b1;
    cmd(1'b0, 1'b0, d);
    note(8'hB7, {~d[7], 7'h00});
    tgl = rdata[6];
    note(8'h40, {1'b0, ~tgl, 6'h00});
    prog_stall <= 1'b0;
    u_fosr_mcu.poll(1'b1);
    note(8'hFF, d);
    u_fosr_mcu.pulses(3);
    prog_stall <= 1'b1;
    cmd(1'b0, 1'b0, d & 8'(rnd()));
    note(8'hFF, d);
    note(8'hFF, d);
    prog_stall <= 1'b0;
    u_fosr_mcu.poll(1'b0);
    d = prog_data;
    cmd(1'b0, 1'b1, 8'h00);
    note(8'hFF, d);
    u_fosr_mcu.pulses(6);
    cmd(1'b1, 1'b1, 8'h00);
    note(8'h80, 8'h00);
    u_fosr_mcu.poll(1'b0);
    note(8'hFF, d);
    u_fosr_mcu.pulses(6);
    cmd(1'b1, 1'b0, 8'h00);
    note(8'h88, 8'h00);
    u_fosr_mcu.poll(1'b1);
    note(8'hFF, 8'hFF);
    prog_stall <= 1'b1;
    u_fosr_mcu.pulses(4);
    cmd(1'b0, 1'b0, 8'(rnd()));
    note(8'h20, 8'h00);
    repeat (40) @(posedge clk);
    prog_stall <= 1'b0;
    u_fosr_mcu.pulses(6);
    bulk();
    note(8'h20, 8'h20);
    u_fosr_mcu.poll(1'b1);
    @(posedge clk);
    cmd_reset <= 1'b1;
    @(posedge clk);
    cmd_reset <= 1'b0;
    u_fosr_mcu.pulses(6);
    bulk();
    note(8'h20, 8'h00);
    erase_fail <= 1'b1;
    note(8'hA0, 8'h20);
    erase_fail <= 1'b0;
    // host moves to the other sector
    u_fosr_mcu.poll(1'b1);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
